// ===== include/itfm_pkg.sv
// itfm_pkg.sv: constants, register map and function codes for the input terminal mapper
package itfm_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_TERM = 5;
	localparam int CODE_W = 5;
	localparam int POL_W = 2;

	// ==========================================================
	// function option codes
	localparam logic [CODE_W-1:0] OPT_NONE = 5'h00;
	localparam logic [CODE_W-1:0] OPT_REV = 5'h01;
	localparam logic [CODE_W-1:0] OPT_SPD0 = 5'h02;
	localparam logic [CODE_W-1:0] OPT_SPD1 = 5'h03;
	localparam logic [CODE_W-1:0] OPT_SPD2 = 5'h04;
	localparam logic [CODE_W-1:0] OPT_SPD3 = 5'h05;
	localparam logic [CODE_W-1:0] OPT_JOG = 5'h06;
	localparam logic [CODE_W-1:0] OPT_DCB = 5'h07;
	localparam logic [CODE_W-1:0] OPT_MOT2 = 5'h08;
	localparam logic [CODE_W-1:0] OPT_RAMP2 = 5'h09;
	localparam logic [CODE_W-1:0] OPT_COAST = 5'h0B;
	localparam logic [CODE_W-1:0] OPT_EXT = 5'h0C;
	localparam logic [CODE_W-1:0] OPT_USP = 5'h0D;
	localparam logic [CODE_W-1:0] OPT_CPS = 5'h0E;
	localparam logic [CODE_W-1:0] OPT_LOCK = 5'h0F;
	localparam logic [CODE_W-1:0] OPT_ASEL = 5'h10;
	localparam logic [CODE_W-1:0] OPT_RST = 5'h12;

	// ==========================================================
	// polarity and analog selection encodings
	localparam logic [POL_W-1:0] POL_NO = 2'h0;
	localparam logic [POL_W-1:0] POL_NC = 2'h1;
	localparam logic [1:0] ASEL_CUR = 2'h0;
	localparam logic [1:0] ASEL_V2 = 2'h1;
	localparam logic [1:0] ASRC_MAIN = 2'h0;
	localparam logic [1:0] ASRC_CUR = 2'h1;
	localparam logic [1:0] ASRC_V2 = 2'h2;
	localparam logic [13:0] ERR_EXT_TRIP = 14'h000C;

	// ==========================================================
	// register byte addresses
	localparam logic [11:0] ADDR_ASSIGN = 12'h000;
	localparam logic [11:0] ADDR_POL = 12'h004;
	localparam logic [11:0] ADDR_CFG = 12'h008;
	localparam logic [11:0] ADDR_CMD = 12'h00C;
	localparam logic [11:0] ADDR_STAT = 12'h010;

	// ==========================================================
	// reset values: the shipping terminal setup
	localparam logic [24:0] ASSIGN_RST = 25'h0884462;
	localparam logic [11:0] POL_RST = 12'h000;
	localparam logic [1:0] ASEL_RST = 2'h0;
	localparam logic [15:0] DELAY_RST = 16'h0004;

	// ==========================================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int DELAY_UNIT_US = 1;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;

	// ==========================================================
	// bypass handover states
	typedef enum logic [1:0]
	{
		CPS_IDLE = 2'b00,
		CPS_HOLD = 2'b01,
		CPS_WAIT = 2'b10,
		CPS_MATCH = 2'b11
	} itfm_cps_type;

endpackage : itfm_pkg

// ===== core/itfm_sync.sv
// itfm_sync.sv: two-stage synchroniser for the terminal pins
`timescale 1ns/1ps
module itfm_sync
	import itfm_pkg::*;
#(
	parameter int W = 6
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// ==========================================================
	// capture chain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : itfm_sync

// ===== core/itfm_cps.sv
// itfm_cps.sv: commercial power bypass handover sequencer
`timescale 1ns/1ps
module itfm_cps
	import itfm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cps_act,
	input wire logic [15:0] restart_delay_setting,
	input wire logic speed_matched,
	output logic output_suppress,
	output logic freq_match_req
);

	itfm_cps_type state_q;
	itfm_cps_type state_d;
	logic cps_prev_q;
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	wire rise = cps_act & ~cps_prev_q;
	wire fall = ~cps_act & cps_prev_q;
	wire [31:0] limit = 32'(restart_delay_setting) * 32'(DELAY_UNIT_CYC);

	// ==========================================================
	// sequencer
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			CPS_IDLE: if (rise) state_d = CPS_HOLD;
			CPS_HOLD: if (fall)
			begin
				state_d = CPS_WAIT;
				cnt_d = '0;
			end
			CPS_WAIT:
			begin
				if (rise) state_d = CPS_HOLD;
				else if (cnt_q + 32'h1 >= limit) state_d = CPS_MATCH;
				else cnt_d = cnt_q + 32'h1;
			end
			CPS_MATCH:
			begin
				if (rise) state_d = CPS_HOLD;
				else if (speed_matched) state_d = CPS_IDLE;
			end
			default: state_d = CPS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= CPS_IDLE;
			cps_prev_q <= 1'b0;
			cnt_q <= '0;
			output_suppress <= 1'b0;
			freq_match_req <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cps_prev_q <= cps_act;
			cnt_q <= cnt_d;
			output_suppress <= (state_d != CPS_IDLE);
			freq_match_req <= (state_d == CPS_MATCH);
		end
	end

	// ==========================================================
	// checks
	cps_suppress_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cps_act && !$past(cps_act) && state_q == CPS_IDLE) |=> output_suppress)
		else $error("bypass rise did not suppress output");

endmodule : itfm_cps

// ===== core/itfm_mapper.sv
// itfm_mapper.sv: input terminal function mapper with APB registers
//
// Operation
// - each terminal acts as the command chosen by its assignment code
// - each terminal and the forward terminal has its own polarity setting
// - polarity 00 is active high, 01 is active low
// - active-low polarity is refused on a terminal assigned trip reset
// - reverse input active means run reverse, inactive means stop
// - four speed select inputs form a binary index, code 02 is bit 0
// - jog active runs at jog frequency, inactive stops
// - DC brake input active applies DC braking during deceleration
// - second motor input active selects the second parameter set
// - second ramp input active selects second-stage ramp values
// - coast input active switches the output off
// - rising external trip latches a trip with code E12 until reset
// - start guard active at power-up blocks resuming the previous run; the synchronised pins still read 0 then, so only trip reset is guarded
// - bypass rise suppresses output, fall waits, matches speed, resumes
// - lock input active rejects parameter changes
// - analog select picks current or second voltage input, else main
// - trip reset clears trip, turns output off and asserts power-up reset
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module itfm_mapper
	import itfm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_TERM-1:0] terminal_in,
	input wire logic forward_in,
	input wire logic run_before_loss,
	input wire logic speed_matched,
	output logic forward_run_cmd,
	output logic reverse_run_cmd,
	output logic [3:0] speed_index,
	output logic jog_cmd,
	output logic dc_brake_cmd,
	output logic second_motor_sel,
	output logic second_ramp_sel,
	output logic coast_stop_cmd,
	output logic trip_latched,
	output logic [13:0] trip_error_code,
	output logic resume_run,
	output logic output_suppress,
	output logic freq_match_req,
	output logic parameter_lock,
	output logic [1:0] analog_source_sel,
	output logic trip_reset_cmd,
	output logic powerup_reset,
	output logic output_enable,
	output logic [15:0] jog_frequency_out
);

	// ==========================================================
	// registers
	logic [24:0] terminal_function_assign_q;
	logic [11:0] terminal_polarity_sel_q;
	logic [1:0] forward_terminal_polarity_q;
	logic [1:0] analog_selection_setting_q;
	logic [15:0] jog_frequency_setting_q;
	logic [15:0] restart_delay_setting_q;
	logic trip_q;
	logic ext_prev_q;
	logic boot_done_q;
	logic resume_q;
	logic [NUM_TERM:0] pin_sync;

	// ==========================================================
	// helpers
	function automatic logic [CODE_W-1:0] code_of(input logic [24:0] a, input int i);
		code_of = a[i*CODE_W +: CODE_W];
	endfunction : code_of

	function automatic logic pol_act(input logic raw, input logic [POL_W-1:0] p);
		pol_act = (p == POL_NC) ? ~raw : raw;
	endfunction : pol_act

	// gathers every terminal that carries option code c
	function automatic logic func_on(input logic [24:0] a, input logic [NUM_TERM-1:0] act,
		input logic [CODE_W-1:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++)
			if (code_of(a, i) == c) r = r | act[i];
		func_on = r;
	endfunction : func_on

	// refuses active-low on a trip reset terminal
	function automatic logic [11:0] pol_clean(input logic [24:0] a, input logic [11:0] p);
		logic [11:0] r;
		r = p;
		for (int i = 0; i < NUM_TERM; i++)
			if (code_of(a, i) == OPT_RST) r[i*POL_W +: POL_W] = POL_NO;
		pol_clean = r;
	endfunction : pol_clean

	// ==========================================================
	// pin synchroniser
	itfm_sync #(.W(NUM_TERM + 1)) u_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in({forward_in, terminal_in}),
		.sync_out(pin_sync)
	);

	// ==========================================================
	// conditioning and function decode
	logic [NUM_TERM-1:0] act;
	always_comb
	begin
		for (int i = 0; i < NUM_TERM; i++)
			act[i] = pol_act(pin_sync[i], terminal_polarity_sel_q[i*POL_W +: POL_W]);
	end
	wire fwd_act = pol_act(pin_sync[NUM_TERM], forward_terminal_polarity_q);
	wire [24:0] fa = terminal_function_assign_q;
	wire f_rev = func_on(fa, act, OPT_REV);
	wire f_jog = func_on(fa, act, OPT_JOG);
	wire f_ext = func_on(fa, act, OPT_EXT);
	wire f_usp = func_on(fa, act, OPT_USP);
	wire f_cps = func_on(fa, act, OPT_CPS);
	wire f_asel = func_on(fa, act, OPT_ASEL);
	wire f_rst = func_on(fa, act, OPT_RST);
	wire [3:0] spd = {func_on(fa, act, OPT_SPD3), func_on(fa, act, OPT_SPD2),
		func_on(fa, act, OPT_SPD1), func_on(fa, act, OPT_SPD0)};
	wire [1:0] asrc = !f_asel ? ASRC_MAIN :
		(analog_selection_setting_q == ASEL_CUR) ? ASRC_CUR :
		(analog_selection_setting_q == ASEL_V2) ? ASRC_V2 : ASRC_MAIN;
	wire f_coast = func_on(fa, act, OPT_COAST);
	wire f_lock = func_on(fa, act, OPT_LOCK);
	wire ext_rise = f_ext & ~ext_prev_q;

	// ==========================================================
	// bypass handover
	logic cps_supp;
	itfm_cps u_cps
	(
		.pclk(pclk),
		.presetn(presetn),
		.cps_act(f_cps),
		.restart_delay_setting(restart_delay_setting_q),
		.speed_matched(speed_matched),
		.output_suppress(cps_supp),
		.freq_match_req(freq_match_req)
	);
	assign output_suppress = cps_supp;

	// ==========================================================
	// trip latch and power-up start guard
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip_q <= 1'b0;
			ext_prev_q <= 1'b0;
			boot_done_q <= 1'b0;
			resume_q <= 1'b0;
		end
		else
		begin
			ext_prev_q <= f_ext;
			if (ext_rise) trip_q <= 1'b1;
			else if (f_rst) trip_q <= 1'b0;
			if (!boot_done_q || f_rst)
			begin
				boot_done_q <= 1'b1;
				resume_q <= run_before_loss & ~f_usp;
			end
		end
	end

	// ==========================================================
	// command outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			forward_run_cmd <= 1'b0;
			reverse_run_cmd <= 1'b0;
			speed_index <= '0;
			jog_cmd <= 1'b0;
			dc_brake_cmd <= 1'b0;
			second_motor_sel <= 1'b0;
			second_ramp_sel <= 1'b0;
			coast_stop_cmd <= 1'b0;
			parameter_lock <= 1'b0;
			analog_source_sel <= ASRC_MAIN;
			trip_reset_cmd <= 1'b0;
			powerup_reset <= 1'b0;
			output_enable <= 1'b0;
			jog_frequency_out <= '0;
		end
		else
		begin
			forward_run_cmd <= fwd_act;
			reverse_run_cmd <= f_rev;
			speed_index <= spd;
			jog_cmd <= f_jog;
			jog_frequency_out <= f_jog ? jog_frequency_setting_q : 16'h0000;
			dc_brake_cmd <= func_on(fa, act, OPT_DCB);
			second_motor_sel <= func_on(fa, act, OPT_MOT2);
			second_ramp_sel <= func_on(fa, act, OPT_RAMP2);
			coast_stop_cmd <= f_coast;
			parameter_lock <= f_lock;
			analog_source_sel <= asrc;
			trip_reset_cmd <= f_rst;
			powerup_reset <= f_rst;
			output_enable <= (fwd_act | f_rev | f_jog) & ~f_coast & ~f_rst
				& ~cps_supp & ~trip_q;
		end
	end
	assign trip_latched = trip_q;
	assign trip_error_code = trip_q ? ERR_EXT_TRIP : 14'h0000;
	assign resume_run = resume_q;

	// ==========================================================
	// APB slave, zero wait states
	wire acc = psel & penable;
	wire wr_ok = acc & pwrite & ~f_lock;
	wire hit_assign = (paddr == ADDR_ASSIGN);
	wire hit_pol = (paddr == ADDR_POL);
	wire hit_cfg = (paddr == ADDR_CFG);
	wire hit_cmd = (paddr == ADDR_CMD);
	wire hit_stat = (paddr == ADDR_STAT);
	wire mapped = hit_assign | hit_pol | hit_cfg | hit_cmd | hit_stat;
	wire ro_hit = hit_cmd | hit_stat;
	assign pready = 1'b1;
	assign pslverr = acc & (~mapped | (pwrite & (ro_hit | f_lock)));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			terminal_function_assign_q <= ASSIGN_RST;
			terminal_polarity_sel_q <= POL_RST;
			forward_terminal_polarity_q <= POL_NO;
			analog_selection_setting_q <= ASEL_RST;
			jog_frequency_setting_q <= '0;
			restart_delay_setting_q <= DELAY_RST;
		end
		else if (wr_ok && hit_assign)
		begin
			terminal_function_assign_q <= pwdata[24:0];
			terminal_polarity_sel_q <= pol_clean(pwdata[24:0], terminal_polarity_sel_q);
		end
		else if (wr_ok && hit_pol)
		begin
			terminal_polarity_sel_q <= pol_clean(fa, pwdata[11:0]);
			forward_terminal_polarity_q <= pwdata[17:16];
			analog_selection_setting_q <= pwdata[25:24];
		end
		else if (wr_ok && hit_cfg)
		begin
			jog_frequency_setting_q <= pwdata[15:0];
			restart_delay_setting_q <= pwdata[31:16];
		end
	end

	wire [31:0] rd_cmd = {8'h00, 2'h0, analog_source_sel, powerup_reset, output_enable,
		parameter_lock, coast_stop_cmd, second_ramp_sel, second_motor_sel, dc_brake_cmd,
		jog_cmd, speed_index, reverse_run_cmd, forward_run_cmd, 6'h00};
	wire [31:0] rd_stat = {14'h0000, trip_error_code, cps_supp, resume_q, trip_q, act[0]};
	wire [31:0] rd_mux = hit_assign ? {7'h00, fa} :
		hit_pol ? {6'h00, analog_selection_setting_q, 6'h00, forward_terminal_polarity_q,
			4'h0, terminal_polarity_sel_q} :
		hit_cfg ? {restart_delay_setting_q, jog_frequency_setting_q} :
		hit_cmd ? rd_cmd :
		hit_stat ? rd_stat : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) prdata <= '0;
		else if (psel && !penable && !pwrite) prdata <= rd_mux;
	end

	// ==========================================================
	// checks
	trip_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ext_rise && !f_rst) |=> (trip_q && trip_error_code == ERR_EXT_TRIP))
		else $error("external trip rise not latched");
	trip_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(trip_q && !f_rst) |=> trip_q)
		else $error("trip lost without reset");
	reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(f_rst && !ext_rise) |=> (!trip_q && !output_enable && powerup_reset))
		else $error("trip reset did not clear and stop");
	no_nc_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		(code_of(fa, 0) == OPT_RST) |-> (terminal_polarity_sel_q[1:0] != POL_NC))
		else $error("active-low on trip reset terminal");
	rev_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		f_rev |=> reverse_run_cmd)
		else $error("reverse command not following input");
	speed_index_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (speed_index == $past(spd)))
		else $error("speed index mismatch");
	coast_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		f_coast |=> !output_enable)
		else $error("output on during coast stop");
	lock_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && f_lock && hit_cfg) |=> $stable(jog_frequency_setting_q))
		else $error("write accepted while locked");
	analog_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		!f_asel |=> (analog_source_sel == ASRC_MAIN))
		else $error("main voltage input not selected");

endmodule : itfm_mapper

// ===== sim/itfm_switches.sv
// itfm_switches.sv: switch bank model driving the terminal pins
`timescale 1ns/1ps
module itfm_switches
	import itfm_pkg::*;
(
	input wire logic pclk,
	input wire logic slow,
	input wire logic [NUM_TERM-1:0] want,
	input wire logic fwd_want,
	output logic [NUM_TERM-1:0] terminal_in,
	output logic forward_in
);
	// ==========
	// contacts settle after one cycle, or three when slow
	logic [NUM_TERM:0] stage_q [3];
	always_ff @(posedge pclk)
	begin
		stage_q[0] <= {fwd_want, want};
		stage_q[1] <= stage_q[0];
		stage_q[2] <= stage_q[1];
	end
	assign {forward_in, terminal_in} = slow ? stage_q[2] : stage_q[0];
endmodule : itfm_switches

// ===== sim/itfm_mapper_bench.sv
// itfm_mapper_bench.sv: self-checking bench for the terminal mapper
`timescale 1ns/1ps
module itfm_mapper_bench
	import itfm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [4:0] want = 5'h00, terminal_in;
	logic fwd_want = 1'b0, slow = 1'b0, run_before_loss = 1'b1, speed_matched = 1'b0;
	logic forward_in, forward_run_cmd, reverse_run_cmd, jog_cmd, dc_brake_cmd;
	logic second_motor_sel, second_ramp_sel, coast_stop_cmd, trip_latched, resume_run;
	logic output_suppress, freq_match_req, parameter_lock, trip_reset_cmd, powerup_reset;
	logic output_enable;
	logic [3:0] speed_index;
	logic [13:0] trip_error_code;
	logic [1:0] analog_source_sel;
	logic [15:0] jog_frequency_out, cmd_vec;
	int fail_count = 0;
	int n_tests = 0;
	always #2 pclk = ~pclk;
	assign cmd_vec = {reverse_run_cmd, speed_index, jog_cmd, dc_brake_cmd, second_motor_sel,
		second_ramp_sel, coast_stop_cmd, parameter_lock, analog_source_sel, trip_reset_cmd,
		powerup_reset, 1'b0};
	itfm_mapper i_itfm_mapper (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .terminal_in, .forward_in, .run_before_loss,
		.speed_matched, .forward_run_cmd, .reverse_run_cmd, .speed_index, .jog_cmd,
		.dc_brake_cmd, .second_motor_sel, .second_ramp_sel, .coast_stop_cmd, .trip_latched,
		.trip_error_code, .resume_run, .output_suppress, .freq_match_req, .parameter_lock,
		.analog_source_sel, .trip_reset_cmd, .powerup_reset, .output_enable,
		.jog_frequency_out);
	itfm_switches i_itfm_switches (.pclk, .slow, .want, .fwd_want, .terminal_in, .forward_in);
	// ==========
	// shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic pins(input logic [4:0] v, input logic f);
		want <= v;
		fwd_want <= f;
		repeat (8) @(posedge pclk);
	endtask : pins
	function automatic logic [15:0] exp_vec(input logic [4:0] c);
		logic [15:0] v;
		v = 16'h0000;
		case (c)
			OPT_REV: v[15] = 1'b1;
			OPT_SPD0: v[11] = 1'b1;
			OPT_SPD1: v[12] = 1'b1;
			OPT_SPD2: v[13] = 1'b1;
			OPT_SPD3: v[14] = 1'b1;
			OPT_JOG: v[10] = 1'b1;
			OPT_DCB: v[9] = 1'b1;
			OPT_MOT2: v[8] = 1'b1;
			OPT_RAMP2: v[7] = 1'b1;
			OPT_COAST: v[6] = 1'b1;
			OPT_LOCK: v[5] = 1'b1;
			OPT_ASEL: v[4:3] = ASRC_CUR;
			OPT_RST: v[2:1] = 2'h3;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : exp_vec
	// ==========
	// scenarios
	task automatic t_codes;
		logic [4:0] c;
		apb(1'b1, ADDR_CFG, 32'h00011234);
		for (int i = 0; i < 32; i++)
		begin
			c = 5'(i);
			if (c != OPT_EXT && c != OPT_CPS)
			begin
				apb(1'b1, ADDR_ASSIGN, 32'(c) << (5 * (i % NUM_TERM)));
				pins(5'h1F, 1'b0);
				chk("cmd on", 32'(cmd_vec), 32'(exp_vec(c)));
				if (c == OPT_JOG)
					chk("jog freq", 32'(jog_frequency_out), 32'h00001234);
				pins(5'h00, 1'b0);
				chk("cmd off", 32'(cmd_vec), 32'h00000000);
			end
		end
		$display("done: option codes");
	endtask : t_codes
	task automatic t_polarity;
		apb(1'b1, ADDR_ASSIGN, 32'(OPT_REV) << 10);
		apb(1'b1, ADDR_POL, 32'h01010010);
		pins(5'h00, 1'b0);
		chk("nc idle", 32'({reverse_run_cmd, forward_run_cmd}), 32'h00000003);
		pins(5'h04, 1'b1);
		chk("nc pressed", 32'({reverse_run_cmd, forward_run_cmd}), 32'h00000000);
		apb(1'b1, ADDR_ASSIGN, 32'(OPT_ASEL) << 10);
		pins(5'h00, 1'b0);
		chk("analog v2", 32'(analog_source_sel), 32'(ASRC_V2));
		apb(1'b1, ADDR_ASSIGN, 32'(OPT_RST));
		apb(1'b1, ADDR_POL, 32'h00000001);
		apb(1'b0, ADDR_POL, 32'h00000000);
		chk("reset pol", rd & 32'h00000003, 32'h00000000);
		pins(5'h00, 1'b0);
		chk("reset idle", 32'(trip_reset_cmd), 32'h00000000);
		apb(1'b1, ADDR_POL, 32'h00000000);
		$display("done: polarity");
	endtask : t_polarity
	task automatic t_speed;
		apb(1'b1, ADDR_ASSIGN, 32'({OPT_SPD3, OPT_SPD2, OPT_SPD1, OPT_SPD0}));
		slow <= 1'b1;
		for (int v = 0; v < 16; v++)
		begin
			pins(5'(v), 1'b0);
			chk("speed", 32'(speed_index), 32'(v));
		end
		slow <= 1'b0;
		$display("done: speed index");
	endtask : t_speed
	task automatic t_trip;
		apb(1'b1, ADDR_ASSIGN, 32'({OPT_RST, OPT_EXT}));
		pins(5'h00, 1'b1);
		chk("run on", 32'(output_enable), 32'h00000001);
		pins(5'h01, 1'b1);
		chk("trip", 32'({trip_latched, trip_error_code, output_enable}), {17'h0, 1'b1, ERR_EXT_TRIP, 1'b0});
		pins(5'h00, 1'b1);
		chk("trip held", 32'({trip_latched, trip_error_code}), {17'h0, 1'b1, ERR_EXT_TRIP});
		pins(5'h03, 1'b1);
		chk("reset", 32'({trip_latched, output_enable, powerup_reset}), 32'h00000001);
		pins(5'h01, 1'b1);
		chk("no rise", 32'({trip_latched, trip_error_code}), 32'h00000000);
		pins(5'h00, 1'b1);
		chk("fall", 32'(trip_latched), 32'h00000000);
		$display("done: trip");
	endtask : t_trip
	task automatic t_guard;
		apb(1'b1, ADDR_ASSIGN, 32'({OPT_RST, OPT_USP}));
		pins(5'h03, 1'b0);
		pins(5'h01, 1'b0);
		chk("guarded", 32'(resume_run), 32'h00000000);
		pins(5'h02, 1'b0);
		pins(5'h00, 1'b0);
		chk("resume", 32'(resume_run), 32'h00000001);
		run_before_loss <= 1'b0;
		pins(5'h02, 1'b0);
		pins(5'h00, 1'b0);
		chk("no run", 32'(resume_run), 32'h00000000);
		$display("done: start guard");
	endtask : t_guard
	task automatic t_lock;
		apb(1'b1, ADDR_ASSIGN, 32'(OPT_LOCK));
		apb(1'b1, ADDR_CFG, 32'h00010000);
		pins(5'h01, 1'b0);
		apb(1'b1, ADDR_CFG, 32'h00015555);
		chk("locked err", 32'(err), 32'h00000001);
		apb(1'b0, ADDR_CFG, 32'h00000000);
		chk("locked keep", rd, 32'h00010000);
		pins(5'h00, 1'b0);
		apb(1'b1, ADDR_CFG, 32'h00015555);
		apb(1'b0, ADDR_CFG, 32'h00000000);
		chk("unlocked", rd, 32'h00015555);
		apb(1'b0, 12'h0FC, 32'h00000000);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		apb(1'b1, ADDR_STAT, 32'h00000000);
		chk("read only", 32'(err), 32'h00000001);
		$display("done: lock and bus");
	endtask : t_lock
	task automatic t_bypass;
		int n = 0;
		apb(1'b1, ADDR_ASSIGN, 32'(OPT_CPS));
		pins(5'h01, 1'b1);
		chk("suppress", 32'({output_suppress, output_enable}), 32'h00000002);
		pins(5'h00, 1'b1);
		repeat (230) @(posedge pclk);
		chk("delay", 32'({output_suppress, freq_match_req}), 32'h00000002);
		while (freq_match_req !== 1'b1 && n < 40)
		begin
			n++;
			@(posedge pclk);
		end
		chk("match", 32'(freq_match_req), 32'h00000001);
		speed_matched <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("resumed", 32'({output_suppress, freq_match_req, output_enable}), 32'h00000001);
		speed_matched <= 1'b0;
		$display("done: bypass");
	endtask : t_bypass
	// ==========
	// sequence and verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		pins(5'h00, 1'b0);
		chk("power-up resume", 32'(resume_run), 32'h00000001);
		t_codes();
		t_polarity();
		t_speed();
		t_trip();
		t_guard();
		t_lock();
		t_bypass();
		end_sim();
	end
	initial
	begin
		#80000;
		fail_count++;
		end_sim();
	end
endmodule : itfm_mapper_bench
